/* File: drum_checker.sv */
// timing assertions on the drum read and test block ports
// assumes a bind onto drum_read_timing; one SYS_CLK domain
`timescale 1ns/1ps
module drum_checker (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic READ_EN,
    input wire logic TEST_GO,
    input wire logic SEC_END_IN,
    input wire logic WORD_CLK,
    input wire logic SECTOR_BEGIN,
    input wire logic BYTE_CLK,
    input wire logic PREAMBLE_DET,
    input wire logic SECTOR_END,
    input wire logic PERR_12,
    input wire logic TEST_DONE
);
    // ==============
    // cycles since the last byte clock, byte index in the sector
    logic       byte_q_r;
    logic [8:0] gap_r;
    logic [5:0] idx_r;
    logic [8:0] wgap_r;
    wire        byte_up = BYTE_CLK && !byte_q_r;
    always_ff @(posedge SYS_CLK) begin
        byte_q_r <= BYTE_CLK && !RST;
        gap_r <= (RST || byte_up) ? 9'h000 : gap_r + 9'(gap_r != 9'h1ff);
        idx_r <= (RST || $rose(SECTOR_BEGIN)) ? 6'h00 : idx_r + 6'(byte_up);
        wgap_r <= (RST || $rose(WORD_CLK)) ? 9'h000 : wgap_r + 9'(wgap_r != 9'h1ff);
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_high(s); s[*8] ##1 s[*6]; endsequence
    property p_gap; $rose(BYTE_CLK) && gap_r < 9'd100 |-> gap_r inside {[9'd59:9'd64]}; endproperty
    a_gap: assert property (p_gap) else $error("byte spacing off");
    property p_pre; $rose(SECTOR_BEGIN) && READ_EN && !TEST_GO |-> ##[318:342] $rose(PREAMBLE_DET);
    endproperty
    a_pre: assert property (p_pre) else $error("preamble late");
    property p_first; $rose(PREAMBLE_DET) |-> ##[58:67] $rose(BYTE_CLK); endproperty
    a_first: assert property (p_first) else $error("first byte off");
    property p_end; $rose(SECTOR_END) |-> gap_r < 9'd25; endproperty
    a_end: assert property (p_end) else $error("sector end late");
    property p_chain; $rose(SECTOR_END) && READ_EN && $past(READ_EN, 8) |-> $rose(SECTOR_BEGIN);
    endproperty
    a_chain: assert property (p_chain) else $error("next begin not coincident");
    property p_pe12; $rose(PERR_12) && !TEST_GO |-> (byte_up && idx_r[1:0] == 2'd1)
        || (gap_r < 9'd3 && idx_r[1:0] == 2'd2); endproperty
    a_pe12: assert property (p_pe12) else $error("parity 1/2 slot off");
    property p_width; $rose(BYTE_CLK) |-> s_high(BYTE_CLK) ##[1:4] !BYTE_CLK; endproperty
    a_width: assert property (p_width) else $error("byte width off");
    property p_word; $rose(WORD_CLK) && wgap_r < 9'd280 |-> wgap_r inside {[9'd246:9'd253]};
    endproperty
    a_word: assert property (p_word) else $error("word clock spacing off");
    property p_done; $rose(TEST_DONE) |-> !SEC_END_IN && !$past(SEC_END_IN, 2); endproperty
    a_done: assert property (p_done) else $error("done too early");
endmodule
bind drum_read_timing drum_checker chk (.*);

/* File: drum_read_and_test_timing_test.sv */
// self-checking bench for the drum read and test timing block
// assumes head_source on the link side and drum_checker bound
`timescale 1ns/1ps
module drum_read_and_test_timing_test;
    import drum_timing_pkg::*;
    logic sys_clk = 1'b0, head_clk = 1'b0, rst = 1'b1;
    logic read_en = 1'b0, test_go = 1'b0, sec_end = 1'b0;
    logic [1:0] test_mode = 2'b00;
    logic h_valid, h_ready, h_par;
    logic [7:0] h_data, data_out, byte_data;
    wire  [NUM_STB-1:0] stb;
    logic [NUM_STB-1:0] stb_q = '0;
    int n [NUM_STB] = '{default: 0};
    int cyc = 0, mismatches = 0, compares = 0;
    always #20 sys_clk = ~sys_clk;
    always #16 head_clk = ~head_clk;
    drum_read_timing dut (.SYS_CLK(sys_clk), .RST(rst), .HEAD_CLK(head_clk),
        .HEAD_DATA(h_data), .HEAD_PARITY(h_par), .HEAD_VALID(h_valid), .HEAD_READY(h_ready),
        .READ_EN(read_en), .TEST_GO(test_go), .TEST_MODE(test_mode), .SEC_END_IN(sec_end),
        .WORD_CLK(stb[STB_WORD]), .SECTOR_BEGIN(stb[STB_SBEG]), .BYTE_CLK(stb[STB_BYTE]),
        .PREAMBLE_DET(stb[STB_PRE]), .SECTOR_END(stb[STB_SEND]), .PERR_12(stb[STB_PE12]),
        .PERR_34(stb[STB_PE34]), .TEST_ERROR(stb[STB_TERR]), .TEST_DONE(stb[STB_DONE]),
        .DATA_OUT(data_out));
    head_source src (.clk(head_clk), .rst(rst), .ready(h_ready), .valid(h_valid),
        .data(h_data), .parity(h_par));
    // ==============
    // rising edges counted per strobe
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        stb_q <= stb;
        for (int k = 0; k < NUM_STB; k++)
            if (stb[k] && !stb_q[k]) n[k] <= n[k] + 1;
        if (stb[STB_BYTE] && !stb_q[STB_BYTE]) byte_data <= data_out;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int k, input int c);
        for (int t = 0; t < 20000 && n[k] < c; t++) @(posedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_read();
        int b, e, p;
        b = n[STB_SBEG];
        e = n[STB_SEND];
        p = n[STB_PE12] * 16 + n[STB_PE34];
        read_en <= 1'b1;
        wait_n(STB_SBEG, b + 1);
        for (int i = 0; i < 32; i++) begin
            if (i == 16) begin
                wait_n(STB_SEND, e + 1);
                check(n[STB_SBEG], b + 2);
                read_en <= 1'b0;
            end
            wait_n(STB_BYTE, n[STB_BYTE] + 1);
            check(byte_data, i);
        end
        wait_n(STB_SEND, e + 2);
        check(n[STB_PE12] * 16 + n[STB_PE34], p + 16);
    endtask
    task automatic t_test1();
        int w, d;
        test_mode <= 2'b00;
        test_go <= 1'b1;
        wait_n(STB_SBEG, n[STB_SBEG] + 1);
        w = n[STB_BYTE];
        wait_n(STB_TERR, n[STB_TERR] + 2);
        check(n[STB_BYTE] - w, 8);
        d = n[STB_DONE];
        sec_end <= 1'b1;
        repeat (22) @(posedge sys_clk);
        sec_end <= 1'b0;
        check(n[STB_DONE], d);
        repeat (20) @(posedge sys_clk);
        check(n[STB_DONE], d + 1);
        test_go <= 1'b0;
    endtask
    task automatic t_short(input logic [1:0] m, input int lo, input int hi, input int k);
        int t, c;
        c = n[STB_BYTE] + n[STB_PE12] + n[STB_PE34] + n[STB_PRE];
        test_mode <= m;
        test_go <= 1'b1;
        wait_n(STB_SBEG, n[STB_SBEG] + 1);
        t = cyc;
        wait_n(STB_DONE, n[STB_DONE] + 1);
        check((cyc - t) inside {[lo:hi]}, 1);
        check(n[STB_BYTE] + n[STB_PE12] + n[STB_PE34] + n[STB_PRE] - c, k);
        test_go <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_read();
        $display("read test done");
        t_test1();
        $display("test mode 1 done");
        for (int m = 1; m < 4; m++) begin
            repeat (10) @(posedge sys_clk);
            t_short(2'(m), m == 1 ? 310 : 60, m == 1 ? 316 : 66, m == 1 ? 9 : 0);
            $display("test mode %0d done", m + 1);
        end
        give_verdict();
    end
    initial begin
        #(40 * 20000);
        mismatches++;
        give_verdict();
    end
endmodule

/* File: drum_read_timing.sv */
// drum memory side of the read and test timing link towards the drum controller
// assumes controller inputs are asynchronous; head data arrives on its own clock
`timescale 1ns/1ps
module drum_read_timing
    import drum_timing_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic       HEAD_CLK,
    input  wire logic [7:0] HEAD_DATA,
    input  wire logic       HEAD_PARITY,
    input  wire logic       HEAD_VALID,
    output logic            HEAD_READY,
    input  wire logic       READ_EN,
    input  wire logic       TEST_GO,
    input  wire logic [1:0] TEST_MODE,
    input  wire logic       SEC_END_IN,
    output logic            WORD_CLK,
    output logic            SECTOR_BEGIN,
    output logic            BYTE_CLK,
    output logic            PREAMBLE_DET,
    output logic            SECTOR_END,
    output logic            PERR_12,
    output logic            PERR_34,
    output logic            TEST_ERROR,
    output logic            TEST_DONE,
    output logic [7:0]      DATA_OUT
);

    // ======================================================================
    // helpers
    function automatic logic hit(input logic tick, input logic [8:0] pos,
                                 input logic [8:0] at);
        return tick && ((pos + 9'd1) == at);
    endfunction

    function automatic logic slot(input logic [8:0] pos, input logic [8:0] first,
                                  input logic [8:0] last);
        logic [8:0] rel;
        rel = pos - first;
        return (pos >= first) && (pos <= last) && (rel[3:0] == 4'h0);
    endfunction

    function automatic logic [4:0] width_of(input int idx);
        return ((idx == STB_SBEG) || (idx == STB_SEND)) ? LONG_CYC : PW_CYC;
    endfunction

    // ======================================================================
    // head clock domain: capture a byte and hand it over by toggle
    logic       hrst1_r;
    logic       hrst2_r;
    logic [8:0] hold_r;
    logic       req_tog_r;
    logic       ack_h;
    logic       ack_r;
    logic       head_rdy_r;

    always_ff @(posedge HEAD_CLK) begin
        hrst1_r <= RST;
        hrst2_r <= hrst1_r;
    end

    level_sync3 #(.W(1)) u_ack_sync (
        .clk (HEAD_CLK),
        .rst (hrst2_r),
        .d   (ack_r),
        .q   (ack_h)
    );

    always_ff @(posedge HEAD_CLK) begin
        if (hrst2_r) begin
            hold_r     <= 9'h000;
            req_tog_r  <= 1'b0;
            head_rdy_r <= 1'b0;
        end else if (head_rdy_r && HEAD_VALID) begin
            hold_r     <= {HEAD_PARITY, HEAD_DATA};
            req_tog_r  <= ~req_tog_r;
            head_rdy_r <= 1'b0;
        end else begin
            // stalls the head until the system side has buffered the byte
            head_rdy_r <= (ack_h == req_tog_r);
        end
    end

    assign HEAD_READY = head_rdy_r;

    // ======================================================================
    // input synchronisers
    logic [5:0] in_s;
    logic       req_s;
    logic       rd_en;
    logic       go;
    logic       se_in;
    logic [1:0] mode;

    level_sync3 #(.W(6)) u_in_sync (
        .clk (SYS_CLK),
        .rst (RST),
        .d   ({req_tog_r, READ_EN, TEST_GO, SEC_END_IN, TEST_MODE}),
        .q   (in_s)
    );

    assign req_s = in_s[5];
    assign rd_en = in_s[4];
    assign go    = in_s[3];
    assign se_in = in_s[2];
    assign mode  = in_s[1:0];

    // ======================================================================
    // two-entry buffer between head hand-over and byte output
    logic       push;
    logic       buf_in_ready;
    logic       buf_valid;
    logic [8:0] buf_data;
    logic       fetch_ev;

    assign push = (req_s != ack_r) && buf_in_ready;

    word_buffer #(.W(9), .DEPTH(2)) u_buf (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_valid  (req_s != ack_r),
        .in_ready  (buf_in_ready),
        .in_data   (hold_r),
        .out_valid (buf_valid),
        .out_ready (fetch_ev),
        .out_data  (buf_data)
    );

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else if (push) begin
            ack_r <= ~ack_r;
        end
    end

    // ======================================================================
    // half bit timebase: fractional accumulator keeps the average exact
    logic [10:0] acc_r;
    logic [10:0] acc_nxt;
    logic        hb_tick;

    always_comb begin
        hb_tick = 1'b0;
        acc_nxt = acc_r + CLK_TENTHS;
        if (acc_nxt >= HB_TENTHS) begin
            hb_tick = 1'b1;
            acc_nxt = acc_nxt - HB_TENTHS;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            acc_r <= 11'h000;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ======================================================================
    // word clock train
    logic [6:0]  word_hb_r;
    logic [10:0] word_idx_r;
    logic [10:0] word_next;
    logic        word_fire;
    logic        skip_word;

    assign word_fire = hb_tick && (word_hb_r ==
                       ((word_idx_r == LAST_WORD) ? GAP_HB_LAST : WORD_HB_LAST));
    assign word_next = (word_idx_r == LAST_WORD) ? FIRST_WORD : word_idx_r + 11'd1;
    assign skip_word = (word_next >= SKIP_FIRST) && (word_next <= LAST_WORD);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            word_hb_r  <= 7'h00;
            word_idx_r <= LAST_WORD;
        end else if (word_fire) begin
            word_hb_r  <= 7'h00;
            word_idx_r <= word_next;
        end else if (hb_tick) begin
            word_hb_r  <= word_hb_r + 7'd1;
        end
    end

    // ======================================================================
    // sequencer
    seq_state_e st_r;
    seq_state_e st_nxt;
    logic [8:0] sec_hb_r;
    logic [4:0] dly_r;
    logic       go_d_r;
    logic       se_d_r;
    logic       pend_r;
    logic [1:0] tmode_r;
    logic       t1_act_r;
    logic       go_rise;
    logic       se_fall;
    logic       start_ev;
    logic       end_now;
    logic       b2b;
    logic [8:0] first_hb;
    logic [8:0] last_hb;
    logic       in_seq;
    logic [8:0] byte_pos;
    logic [8:0] fetch_pos;
    logic [8:0] byte_rel;
    logic [8:0] fetch_rel;
    logic       byte_ev;
    logic [1:0] lane;
    logic [3:0] err_r;

    assign go_rise  = go && !go_d_r;
    assign se_fall  = !se_in && se_d_r;
    assign start_ev = (st_r == ST_IDLE) && word_fire && (pend_r || rd_en);
    assign end_now  = (st_r == ST_REND) && (dly_r == 5'd0);
    assign b2b      = end_now && rd_en && !pend_r;

    always_comb begin
        first_hb = BYTE0_HB;
        last_hb  = LAST_BYTE_HB;
        in_seq   = 1'b0;
        unique case (st_r)
            ST_READ: begin
                in_seq = 1'b1;
            end
            ST_T1: begin
                first_hb = T1_BYTE0_HB;
                last_hb  = T1_LAST_HB;
                in_seq   = t1_act_r;
            end
            ST_T2: begin
                first_hb = T2_BYTE0_HB;
                last_hb  = T2_LAST_HB;
                in_seq   = 1'b1;
            end
            ST_IDLE, ST_REND, ST_T34: begin
                in_seq = 1'b0;
            end
        endcase
    end

    assign byte_pos  = sec_hb_r + 9'd1;
    assign fetch_pos = sec_hb_r + FETCH_LEAD;
    assign byte_rel  = byte_pos - first_hb;
    assign fetch_rel = fetch_pos - first_hb;
    assign lane      = byte_rel[5:4];
    assign byte_ev   = hb_tick && in_seq && slot(byte_pos, first_hb, last_hb);
    assign fetch_ev  = hb_tick && in_seq && slot(fetch_pos, first_hb, last_hb);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: begin
                if (start_ev && pend_r) begin
                    unique case (tmode_r)
                        TM_ONE:            st_nxt = ST_T1;
                        TM_TWO:            st_nxt = ST_T2;
                        TM_THREE, TM_FOUR: st_nxt = ST_T34;
                    endcase
                end else if (start_ev) begin
                    st_nxt = ST_READ;
                end
            end
            ST_READ: begin
                if (byte_ev && (byte_pos == LAST_BYTE_HB)) begin
                    st_nxt = ST_REND;
                end
            end
            ST_REND: begin
                if (end_now) begin
                    st_nxt = b2b ? ST_READ : ST_IDLE;
                end
            end
            ST_T1: begin
                if (se_fall) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_T2: begin
                if (hit(hb_tick, sec_hb_r, T2_DONE_HB)) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_T34: begin
                if (hit(hb_tick, sec_hb_r, T34_DONE_HB)) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // test request: a go edge that lands on the start cycle still counts
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            go_d_r  <= 1'b0;
            se_d_r  <= 1'b0;
            pend_r  <= 1'b0;
            tmode_r <= TM_ONE;
        end else begin
            go_d_r <= go;
            se_d_r <= se_in;
            if (go_rise) begin
                pend_r  <= 1'b1;
                tmode_r <= mode;
            end else if (start_ev) begin
                pend_r  <= 1'b0;
            end
        end
    end

    // one half bit counter, restarted at each reference strobe
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sec_hb_r <= 9'h000;
            t1_act_r <= 1'b0;
        end else if (start_ev || b2b || ((st_r == ST_T1) && word_fire)) begin
            sec_hb_r <= 9'h000;
            t1_act_r <= !skip_word;
        end else if (hb_tick && (sec_hb_r != 9'h1ff)) begin
            sec_hb_r <= sec_hb_r + 9'd1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dly_r <= 5'd0;
        end else if ((st_r == ST_READ) && (st_nxt == ST_REND)) begin
            dly_r <= END_DLY_CYC - 5'd1;
        end else if (dly_r != 5'd0) begin
            dly_r <= dly_r - 5'd1;
        end
    end

    // ======================================================================
    // data path: byte fetched one bit (two half bits) ahead so it is settled
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
            err_r    <= 4'h0;
        end else if (fetch_ev) begin
            // an empty buffer shows as zero data flagged in error
            DATA_OUT             <= buf_valid ? buf_data[7:0] : 8'h00;
            err_r[fetch_rel[5:4]] <= buf_valid ? ~(^buf_data) : 1'b1;
        end
    end

    // ======================================================================
    // strobe requests
    logic [NUM_STB-1:0] fire;
    logic [NUM_STB-1:0] stb_w;

    always_comb begin
        fire           = '0;
        fire[STB_WORD] = word_fire;
        fire[STB_SBEG] = start_ev || b2b;
        fire[STB_BYTE] = byte_ev;
        fire[STB_SEND] = end_now;
        fire[STB_TERR] = (st_r == ST_T1) && word_fire && !skip_word;
        if (st_r == ST_READ) begin
            fire[STB_PRE]  = hit(hb_tick, sec_hb_r, PRE_HB);
            fire[STB_PE12] = byte_ev && (lane == 2'd1) && (err_r[0] || err_r[1]);
            fire[STB_PE34] = byte_ev && (lane == 2'd3) && (err_r[2] || err_r[3]);
        end
        if (st_r == ST_T2) begin
            fire[STB_PRE]  = byte_ev && (lane == 2'd1);
            fire[STB_PE34] = hit(hb_tick, sec_hb_r, T2_PE34_HB) ||
                             (byte_ev && (lane == 2'd1));
            fire[STB_PE12] = hit(hb_tick, sec_hb_r, T2_PE12_HB) ||
                             (byte_ev && (lane == 2'd3));
        end
        fire[STB_DONE] = ((st_r == ST_T1) && se_fall) ||
                         ((st_r == ST_T2) && hit(hb_tick, sec_hb_r, T2_DONE_HB)) ||
                         ((st_r == ST_T34) && hit(hb_tick, sec_hb_r, T34_DONE_HB));
    end

    // ======================================================================
    // pulse stretchers, one per strobe
    genvar g;
    generate
        for (g = 0; g < NUM_STB; g++) begin : g_stb
            logic [4:0] cnt_r;
            logic       out_r;

            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    cnt_r <= 5'd0;
                    out_r <= 1'b0;
                end else if (fire[g]) begin
                    cnt_r <= width_of(g) - 5'd1;
                    out_r <= 1'b1;
                end else if (cnt_r != 5'd0) begin
                    cnt_r <= cnt_r - 5'd1;
                end else begin
                    out_r <= 1'b0;
                end
            end

            assign stb_w[g] = out_r;
        end
    endgenerate

    assign WORD_CLK     = stb_w[STB_WORD];
    assign SECTOR_BEGIN = stb_w[STB_SBEG];
    assign BYTE_CLK     = stb_w[STB_BYTE];
    assign PREAMBLE_DET = stb_w[STB_PRE];
    assign SECTOR_END   = stb_w[STB_SEND];
    assign PERR_12      = stb_w[STB_PE12];
    assign PERR_34      = stb_w[STB_PE34];
    assign TEST_ERROR   = stb_w[STB_TERR];
    assign TEST_DONE    = stb_w[STB_DONE];

endmodule

/* File: drum_timing_pkg.sv */
// timing constants, strobe indices and state codes of the drum read/test timing block
// assumes a 25 MHz system clock; link times are kept in half bit times except the strobe widths and the sector end delay, kept in ns
// Functional notes
// - byte clocks of a sector or test pattern come exactly eight bit times apart
// - preamble detect comes 41 to 43.5 bit times after the sector begin position
// - first byte clock follows preamble detect by 7.5 to 8.5 bit times
// - sector end rises 0 to 1.0 us after the last byte clock of the sector
// - back-to-back sector begin coincides with sector end, otherwise with a word clock
// - byte 1/2 parity error slots every 32 bits, first at the second byte clock
// - byte 3/4 parity error slots every 32 bits, first at the fourth byte clock
// - strobes last 0.55-0.70 us; sector begin and end last 0.85 +/- 0.30 us
// - N bit times means 312.8*N ns within one percent plus or minus 50 ns
// - test 1 repeats error strobe, bytes and data each word except words 1242-1249
// - test 1 completion strobe starts only after the sector end strobe has ended
// - test 2 parity 3/4 strobes 1.5-4.5 bits after byte one, then at byte two
// - test 2 parity 1/2 strobes 1.5-4.5 bits after byte three, then at byte four
// - test 2 preamble detect comes at the second byte clock
// - a later sector begin may coincide with any later word clock
// - word clocks 32 bit times apart, gap 1249 to 1 spans 16 to 48 bits
package drum_timing_pkg;

    // ======================================================================
    // timebase, in tenths of a nanosecond so that 312.8 ns stays exact
    localparam int unsigned CLK_NS       = 40;
    localparam int unsigned BIT_TENTHS   = 3128;
    localparam logic [10:0] CLK_TENTHS   = 11'(CLK_NS * 10);
    localparam logic [10:0] HB_TENTHS    = 11'(BIT_TENTHS / 2);

    // ======================================================================
    // word clock train, positions in half bit times
    localparam logic [6:0]  WORD_HB_LAST = 7'd63;
    localparam logic [6:0]  GAP_HB_LAST  = 7'd79;
    localparam logic [10:0] LAST_WORD    = 11'd1249;
    localparam logic [10:0] FIRST_WORD   = 11'd1;
    localparam logic [10:0] SKIP_FIRST   = 11'd1242;

    // ======================================================================
    // read sector layout, half bits after the sector begin position
    localparam int unsigned SECTOR_WORDS = 4;
    localparam logic [8:0]  PRE_HB       = 9'd84;
    localparam logic [8:0]  BYTE0_HB     = 9'd100;
    localparam logic [8:0]  LAST_BYTE_HB = 9'(100 + 16 * (SECTOR_WORDS * 4 - 1));
    localparam int unsigned END_DLY_NS   = 480;
    localparam logic [4:0]  END_DLY_CYC  = 5'(END_DLY_NS / CLK_NS);

    // ======================================================================
    // test patterns, half bits after the word clock that starts them
    localparam logic [8:0]  T1_BYTE0_HB  = 9'd8;
    localparam logic [8:0]  T1_LAST_HB   = 9'd56;
    localparam logic [8:0]  T2_BYTE0_HB  = 9'd16;
    localparam logic [8:0]  T2_LAST_HB   = 9'd64;
    localparam logic [8:0]  T2_PE34_HB   = 9'd22;
    localparam logic [8:0]  T2_PE12_HB   = 9'd54;
    localparam logic [8:0]  T2_DONE_HB   = 9'd80;
    localparam logic [8:0]  T34_DONE_HB  = 9'd16;
    localparam logic [8:0]  FETCH_LEAD   = 9'd3;

    // ======================================================================
    // strobe widths; least width rounds up
    localparam int unsigned PW_NS        = 600;
    localparam int unsigned LONG_NS      = 850;
    localparam logic [4:0]  PW_CYC       = 5'((PW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0]  LONG_CYC     = 5'((LONG_NS + CLK_NS - 1) / CLK_NS);

    // ======================================================================
    // strobe indices and modes
    localparam int NUM_STB  = 9;
    localparam int STB_WORD = 0;
    localparam int STB_SBEG = 1;
    localparam int STB_BYTE = 2;
    localparam int STB_PRE  = 3;
    localparam int STB_SEND = 4;
    localparam int STB_PE12 = 5;
    localparam int STB_PE34 = 6;
    localparam int STB_TERR = 7;
    localparam int STB_DONE = 8;

    typedef enum logic [1:0] {
        TM_ONE   = 2'b00,
        TM_TWO   = 2'b01,
        TM_THREE = 2'b10,
        TM_FOUR  = 2'b11
    } test_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_REND = 3'b010,
        ST_T1   = 3'b011,
        ST_T2   = 3'b100,
        ST_T34  = 3'b101
    } seq_state_e;

endpackage

/* File: head_source.sv */
// head byte source model for the link side of the drum block
// assumes a transfer on each clk edge with valid and ready both high
`timescale 1ns/1ps
module head_source (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ready,
    output logic      valid,
    output logic [7:0] data,
    output logic      parity
);
    // ==============
    // counting bytes; 8'h05 goes out with bad parity
    always_ff @(posedge clk) begin
        if (rst) begin
            valid <= 1'b0;
            data <= 8'hff;
        end else if (valid && ready) begin
            data <= data + 8'h01;
        end else begin
            valid <= 1'b1;
            data <= valid ? data : 8'h00;
        end
    end
    assign parity = ~^data ^ (data == 8'h05);
endmodule

/* File: level_sync3.sv */
// three flip-flop synchroniser for a group of level signals
// assumes rst is synchronous to clk; output moves once stages two and three agree
`timescale 1ns/1ps
module level_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // glitch of one sample is ignored until two stages agree
            q    <= (s2_r & s3_r) | (q & (s2_r | s3_r));
        end
    end
endmodule

/* File: word_buffer.sv */
// small fifo with valid/ready on both sides
// assumes DEPTH is a power of two; single clock, synchronous reset
`timescale 1ns/1ps
module word_buffer #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic         full;
    logic         empty;

    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule
